// file: bench/scrb_bank_bench.sv
`timescale 1ns/1ns
`default_nettype none
module scrb_bank_bench;
    import scrb_pkg::*;
    localparam logic [7:0] KEY = 8'hc3;
    logic i_clk_sys, i_rst_b, i_color_mode, o_rd_hit, o_unlocked, o_ext_unlocked;
    logic [7:0] o_rdata;
    scrb_io_t i_io;
    scrb_ctrl_t o_ctrl;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    scrb_bank #(.UNLOCK_KEY(KEY)) scrb_bank_i (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
        .i_color_mode(i_color_mode), .i_io(i_io), .o_rdata(o_rdata), .o_rd_hit(o_rd_hit),
        .o_unlocked(o_unlocked), .o_ext_unlocked(o_ext_unlocked), .o_ctrl(o_ctrl));
    // 100 MHz clock
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    // One bus cycle, launched at an edge and sampled at the next
    task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic w, input logic r);
        i_io <= '{addr: a, wdata: d, wr: w, rd: r};
        @(posedge i_clk_sys);
    endtask
    function automatic logic [15:0] port(input logic dat);
        if (i_color_mode) return dat ? SCRB_PORT_DATA_COLOR : SCRB_PORT_INDEX_COLOR;
        return dat ? SCRB_PORT_DATA_MONO : SCRB_PORT_INDEX_MONO;
    endfunction
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("unexpected %s: expected %h, seen %h", s, e, g);
            n_mismatch++;
        end
    endtask
    // Index then data write; waits until the controls follow
    task automatic wr(input logic [7:0] n, input logic [7:0] d);
        cyc(port(1'b0), n, 1'b1, 1'b0);
        cyc(port(1'b1), d, 1'b1, 1'b0);
        i_io <= '0;
        repeat (2) @(posedge i_clk_sys);
    endtask
    // Read data stands one cycle only, so look just after the edge
    task automatic rd(input logic [7:0] n, input logic [7:0] e, input logic h);
        cyc(port(1'b0), n, 1'b1, 1'b0);
        cyc(port(1'b1), 8'h00, 1'b0, 1'b1);
        i_io <= '0;
        #1;
        chk("read data", {24'h0, e}, {24'h0, o_rdata});
        chk("read hit", {31'h0, h}, {31'h0, o_rd_hit});
        @(posedge i_clk_sys);
    endtask
    task automatic t_locked;
        chk("unlocked", 0, o_unlocked);
        wr(SCRB_IDX_CUR_MODE, 8'h01);
        chk("cursor_en", 0, o_ctrl.cursor_en);
        rd(SCRB_IDX_SYS_CFG, 8'h00, 1'b0);
        $display("test locked done");
    endtask
    task automatic t_unlock;
        wr(SCRB_IDX_LOCK2, KEY);
        chk("ext_unlocked", 1, o_ext_unlocked);
        rd(SCRB_IDX_LOCK2, KEY, 1'b1);
        rd(SCRB_IDX_SYS_CFG, 8'h20, 1'b1);
        $display("test unlock done");
    endtask
    task automatic t_fields;
        wr(SCRB_IDX_SYS_CFG, 8'h11);
        chk("cfg bits", 2'b11, {o_ctrl.enh_access_en, o_ctrl.rdy_wait_ctrl});
        rd(SCRB_IDX_SYS_CFG, 8'h31, 1'b1);
        wr(SCRB_IDX_EXT_MODE, 8'h84);
        chk("ext bits", 2'b11, {o_ctrl.hcount_double, o_ctrl.width_bit8});
        wr(SCRB_IDX_CUR_MODE, 8'h11);
        chk("cursor bits", 2'b11, {o_ctrl.cursor_space, o_ctrl.cursor_en});
        wr(SCRB_IDX_BIOS, 8'h5a);
        rd(SCRB_IDX_BIOS, 8'h5a, 1'b1);
        wr(SCRB_IDX_MODE, 8'h20);
        chk("interlace", 1, o_ctrl.interlace);
        wr(SCRB_IDX_ORG_X_LO, 8'hff);
        wr(SCRB_IDX_ORG_X_HI, 8'hff);
        chk("origin_x", 11'h7ff, o_ctrl.origin_x);
        rd(SCRB_IDX_ORG_X_HI, 8'hff, 1'b1);
        wr(SCRB_IDX_ORG_Y_LO, 8'h34);
        wr(SCRB_IDX_ORG_Y_HI, 8'h05);
        chk("origin_y", 11'h534, o_ctrl.origin_y);
        wr(SCRB_IDX_PAT_LO, 8'hff);
        wr(SCRB_IDX_PAT_HI, 8'h3f);
        chk("pattern_addr", 13'h1fff, o_ctrl.pattern_addr);
        wr(SCRB_IDX_OFS_X, 8'hff);
        chk("offset_x", 6'h3f, o_ctrl.offset_x);
        wr(SCRB_IDX_OFS_Y, 8'h2a);
        chk("offset_y", 6'h2a, o_ctrl.offset_y);
        rd(8'h44, 8'h00, 1'b0);
        $display("test fields done");
    endtask
    // Stacks: one index write, then three data writes back to back
    task automatic t_stack;
        cyc(port(1'b0), SCRB_IDX_FG, 1'b1, 1'b0);
        cyc(port(1'b1), 8'h11, 1'b1, 1'b0);
        cyc(port(1'b1), 8'h22, 1'b1, 1'b0);
        cyc(port(1'b1), 8'h33, 1'b1, 1'b0);
        cyc(port(1'b0), SCRB_IDX_BG, 1'b1, 1'b0);
        cyc(port(1'b1), 8'h44, 1'b1, 1'b0);
        cyc(port(1'b1), 8'h55, 1'b1, 1'b0);
        cyc(port(1'b1), 8'h66, 1'b1, 1'b0);
        i_io <= '0;
        repeat (2) @(posedge i_clk_sys);
        chk("fg_color", 24'h332211, o_ctrl.fg_color);
        chk("bg_color", 24'h665544, o_ctrl.bg_color);
        rd(SCRB_IDX_FG, 8'h11, 1'b1);
        rd(SCRB_IDX_BG, 8'h44, 1'b1);
        $display("test stack done");
    endtask
    // Mono decode: color ports must then be ignored
    task automatic t_mono;
        i_color_mode <= 1'b0;
        @(posedge i_clk_sys);
        wr(SCRB_IDX_CUR_MODE, 8'h00);
        chk("cursor off", 0, o_ctrl.cursor_en);
        cyc(SCRB_PORT_INDEX_COLOR, SCRB_IDX_CUR_MODE, 1'b1, 1'b0);
        cyc(SCRB_PORT_DATA_COLOR, 8'h01, 1'b1, 1'b0);
        i_io <= '0;
        repeat (2) @(posedge i_clk_sys);
        chk("cursor via color", 0, o_ctrl.cursor_en);
        i_color_mode <= 1'b1;
        @(posedge i_clk_sys);
        $display("test mono done");
    endtask
    task automatic t_relock;
        wr(SCRB_IDX_LOCK2, KEY ^ 8'h01);
        chk("relocked", 0, o_unlocked);
        wr(SCRB_IDX_BIOS, 8'h00);
        rd(SCRB_IDX_BIOS, 8'h00, 1'b0);
        wr(SCRB_IDX_LOCK2, KEY);
        rd(SCRB_IDX_BIOS, 8'h5a, 1'b1);
        $display("test relock done");
    endtask
    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Hang guard, well above the roughly 140 cycles the tests take
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            end_sim();
        end
    end
    initial begin
        i_rst_b = 1'b0;
        i_color_mode = 1'b1;
        i_io = '0;
        repeat (12) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        @(posedge i_clk_sys);
        t_locked();
        t_unlock();
        t_fields();
        t_stack();
        t_mono();
        t_relock();
        end_sim();
    end
endmodule
`default_nettype wire

// file: bench/scrb_bank_props.sv
`timescale 1ns/1ns
`default_nettype none
module scrb_bank_props
    import scrb_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_color_mode,
    input wire scrb_pkg::scrb_io_t i_io,
    input wire logic [7:0] o_rdata,
    input wire logic o_rd_hit,
    input wire logic o_unlocked,
    input wire logic o_ext_unlocked,
    input wire scrb_pkg::scrb_ctrl_t o_ctrl
);
    logic [7:0] idx;
    logic [15:0] dport;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    // Data port follows the mono or color decode
    assign dport = i_color_mode ? SCRB_PORT_DATA_COLOR : SCRB_PORT_DATA_MONO;
    // Shadow of the index register, kept from the index port
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            idx <= 8'h00;
        end else if (i_io.wr && i_io.addr == dport - 16'h0001) begin
            idx <= i_io.wdata;
        end
    end
    // Open data write and any data read at a given index
    sequence s_dwr(logic [7:0] n);
        i_io.wr && i_io.addr == dport && idx == n && o_unlocked;
    endsequence
    sequence s_drd(logic [7:0] n);
        i_io.rd && i_io.addr == dport && idx == n;
    endsequence
    ext_lock_a: assert property (o_ext_unlocked == o_unlocked)
        else $error("extension lock differs");
    unlock_cause_a: assert property ($changed(o_unlocked) |-> $past(i_io.wr))
        else $error("lock state moved without a write");
    lock_rd_a: assert property (s_drd(SCRB_IDX_SYS_CFG) ##0 !o_unlocked |=>
        !o_rd_hit && o_rdata == 8'h00) else $error("locked read leaked");
    locked_wr_a: assert property (i_io.wr && i_io.addr == dport && idx[7:4] == 4'h4
        && !o_unlocked |=> ##1 $stable(o_ctrl)) else $error("locked write landed");
    cfg_rd_a: assert property (s_drd(SCRB_IDX_SYS_CFG) ##0 o_unlocked |=>
        o_rd_hit && o_rdata[5]) else $error("config read wrong");
    cfg_wr_a: assert property (s_dwr(SCRB_IDX_SYS_CFG) |-> ##2
        o_ctrl.enh_access_en == $past(i_io.wdata[0], 2)
        && o_ctrl.rdy_wait_ctrl == $past(i_io.wdata[4], 2)) else $error("config bits wrong");
    ext_wr_a: assert property (s_dwr(SCRB_IDX_EXT_MODE) |-> ##2
        {o_ctrl.hcount_double, o_ctrl.width_bit8}
        == {$past(i_io.wdata[7], 2), $past(i_io.wdata[2], 2)}) else $error("ext mode wrong");
    cur_wr_a: assert property (s_dwr(SCRB_IDX_CUR_MODE) |-> ##2
        {o_ctrl.cursor_space, o_ctrl.cursor_en}
        == {$past(i_io.wdata[4], 2), $past(i_io.wdata[0], 2)}) else $error("cursor mode wrong");
    bios_wr_a: assert property (s_dwr(SCRB_IDX_BIOS) |-> ##2
        o_ctrl.bios_flag == $past(i_io.wdata, 2)) else $error("bios flag wrong");
    ofs_wr_a: assert property (s_dwr(SCRB_IDX_OFS_X) |-> ##2
        o_ctrl.offset_x == $past(i_io.wdata[5:0], 2)) else $error("offset x wrong");
    ctrl_cause_a: assert property ($changed(o_ctrl) |-> $past(i_io.wr, 2))
        else $error("controls moved without a write");
endmodule
bind scrb_bank scrb_bank_props scrb_bank_props_i (.i_clk_sys, .i_rst_b, .i_color_mode,
    .i_io, .o_rdata, .o_rd_hit, .o_unlocked, .o_ext_unlocked, .o_ctrl);
`default_nettype wire

// file: rtl/scrb_bank.sv
`timescale 1ns/1ns
`default_nettype none

// Register map of the bank, reached through the shared data port
// Index 39h: lock byte, always reachable, never itself locked
// Index 40h: system configuration
//   bit 0 enhanced register access enable
//   bits 3-1 reserved, stored as written
//   bit 4 ready wait-state control for the local bus
//   bit 5 reserved, forced to one on every write
//   bits 7-6 reserved, stored as written
// Index 41h: BIOS scratch byte, no hardware effect
// Index 42h: mode control
//   bit 5 interlaced scan select
//   other bits reserved, stored as written
// Index 43h: extended mode
//   bit 2 legacy logical screen width bit 8
//   bit 7 doubled horizontal counting
// Index 44h: unmapped; writes dropped, reads give zero and no hit
// Index 45h: cursor mode
//   bit 0 cursor overlay enable
//   bit 4 reserve space right of the bitmap
// Index 46h/47h: cursor X origin, low then high byte
// Index 48h/49h: cursor Y origin, low then high byte
//   only bits 10-0 reach the display logic
// Index 4Ah: foreground color stack, three entries
// Index 4Bh: background color stack, three entries
// Index 4Ch/4Dh: cursor pattern start, bits 12-0 used
// Index 4Eh: pattern start column, bits 5-0 used
// Index 4Fh: pattern start line, bits 5-0 used

// Access sequence seen by the host
//   1. write index 39h to the index port
//   2. write the key to the data port
//   3. write a bank index to the index port
//   4. read or write the data port, once per byte
// A locked bank answers reads other than the lock byte with zero and no hit, so a driver
// probing for the bank sees a clean miss rather than stale data.
// The key compare covers all eight bits; a one-bit slip relocks,
// the safer failure for a register set that moves display timing.
// Indices outside 39h and 40h-4Fh belong to other banks and are
// ignored here, so several banks can share the same two ports.
// The index is cleared only by the hardware reset, the pointers also by an index write;
// software must not rely on state left by an earlier driver.

module scrb_bank #(
    parameter logic [7:0] UNLOCK_KEY = scrb_pkg::SCRB_UNLOCK_KEY
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_color_mode,
    input wire scrb_pkg::scrb_io_t i_io,
    output logic [7:0] o_rdata,
    output logic o_rd_hit,
    output logic o_unlocked,
    output logic o_ext_unlocked,
    output scrb_pkg::scrb_ctrl_t o_ctrl
);
    import scrb_pkg::*;

    // Bank state: index, lock byte and the stored registers.
    // Words are kept at full sixteen bits so reserved bits read
    // back as written; only the used bits leave the bank.
    logic [7:0] index_reg;
    logic [7:0] lock_reg;
    logic [7:0] sys_cfg;
    logic [7:0] bios_flag;
    logic [7:0] mode_ctl;
    logic [7:0] ext_mode;
    logic [7:0] cur_mode;
    logic [15:0] org_x;
    logic [15:0] org_y;
    logic [15:0] pat_addr;
    logic [7:0] ofs_x;
    logic [7:0] ofs_y;
    logic [7:0] fg_stack [SCRB_STACK_DEPTH];
    logic [7:0] bg_stack [SCRB_STACK_DEPTH];
    logic [1:0] fg_ptr;
    logic [1:0] bg_ptr;
    logic unlocked;
    logic idx_sel;
    logic data_sel;
    logic in_bank;
    logic bank_wr;
    logic bank_rd;
    logic [7:0] next_rdata;
    logic next_rd_hit;

    // Timing at the ports
    //   edge N: strobe and address sampled, register written
    //   edge N: read data and hit flag registered, standing for one cycle
    //   edge N+1: control outputs follow a write landed at edge N
    // Control outputs are registered once more so the display side
    // sees a clean flop output rather than the decode of the bus.
    // The price is one cycle of lag, harmless for settings that
    // software changes only between frames.

    // Stack pointer wraps after the third entry
    function automatic logic [1:0] scrb_ptr_step(input logic [1:0] p);
        return (p == 2'(SCRB_STACK_DEPTH - 1)) ? 2'h0 : p + 2'h1;
    endfunction

    // Port decode. Only one pair of ports answers at a time, so a
    // mono driver cannot disturb a bank running in color mode.
    // The bank window is the whole 40h-4Fh row; holes in it are
    // left to the read mux, which gives no hit for them.

    // Index ports follow the mono/color decode
    assign idx_sel = i_io.addr == (i_color_mode ? SCRB_PORT_INDEX_COLOR : SCRB_PORT_INDEX_MONO);
    assign data_sel = i_io.addr == (i_color_mode ? SCRB_PORT_DATA_COLOR : SCRB_PORT_DATA_MONO);
    assign in_bank = index_reg[7:4] == SCRB_IDX_SYS_CFG[7:4];
    // Full byte compare; near-miss keys stay locked
    assign unlocked = lock_reg == UNLOCK_KEY;
    assign bank_wr = i_io.wr && data_sel && in_bank && unlocked;
    assign bank_rd = i_io.rd && data_sel && in_bank && unlocked;
    assign o_unlocked = unlocked;
    assign o_ext_unlocked = unlocked;

    // The index is latched for every index-port write, whatever
    // the lock state; otherwise the lock byte could not be reached.

    // Index latch, shared by the whole extended space
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            index_reg <= SCRB_RST_BYTE;
        end else if (i_io.wr && idx_sel) begin
            index_reg <= i_io.wdata;
        end
    end

    // Lock byte also gates the extension bank through the
    // separate unlocked output, so both banks open together.

    // Lock register itself is never locked, otherwise no way in
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            lock_reg <= SCRB_RST_LOCK;
        end else if (i_io.wr && data_sel && index_reg == SCRB_IDX_LOCK2) begin
            lock_reg <= i_io.wdata;
        end
    end

    // Single-byte registers. A write lands at the edge that samples
    // the data strobe; the hole at 44h falls to the default branch.

    // Byte registers of the bank
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sys_cfg <= SCRB_RST_SYS_CFG;
            bios_flag <= SCRB_RST_BYTE;
            mode_ctl <= SCRB_RST_BYTE;
            ext_mode <= SCRB_RST_BYTE;
            cur_mode <= SCRB_RST_BYTE;
            ofs_x <= SCRB_RST_BYTE;
            ofs_y <= SCRB_RST_BYTE;
        end else if (bank_wr) begin
            case (index_reg)
                SCRB_IDX_SYS_CFG: begin
                    // Bit 5 held at one whatever is written
                    sys_cfg <= i_io.wdata | (8'h01 << SCRB_CFG_ONE_BIT);
                end
                SCRB_IDX_BIOS: bios_flag <= i_io.wdata;
                SCRB_IDX_MODE: mode_ctl <= i_io.wdata;
                SCRB_IDX_EXT_MODE: ext_mode <= i_io.wdata;
                SCRB_IDX_CUR_MODE: cur_mode <= i_io.wdata;
                SCRB_IDX_OFS_X: ofs_x <= i_io.wdata;
                SCRB_IDX_OFS_Y: ofs_y <= i_io.wdata;
                default: begin
                end
            endcase
        end
    end

    // Words are written one byte at a time, so the display side may
    // see a half-updated origin for two cycles or more between the two
    // writes; software moving the cursor should do so in blanking.

    // Two-index words, low byte at the even index
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            org_x <= SCRB_RST_WORD;
            org_y <= SCRB_RST_WORD;
            pat_addr <= SCRB_RST_WORD;
        end else if (bank_wr) begin
            case (index_reg)
                SCRB_IDX_ORG_X_LO: org_x[7:0] <= i_io.wdata;
                SCRB_IDX_ORG_X_HI: org_x[15:8] <= i_io.wdata;
                SCRB_IDX_ORG_Y_LO: org_y[7:0] <= i_io.wdata;
                SCRB_IDX_ORG_Y_HI: org_y[15:8] <= i_io.wdata;
                SCRB_IDX_PAT_LO: pat_addr[7:0] <= i_io.wdata;
                SCRB_IDX_PAT_HI: pat_addr[15:8] <= i_io.wdata;
                default: begin
                end
            endcase
        end
    end

    // Stack pointer sequence for one index
    //   index write: pointer back to entry 0
    //   first data access: entry 0, pointer to 1
    //   second data access: entry 1, pointer to 2
    //   third data access: entry 2, pointer back to 0
    // Reads advance the pointer too, so a read-back after a write
    // needs a fresh index write to start again from entry 0.
    // A data access moves only the pointer of the addressed stack; an index write clears both.

    // Color stacks: each unlocked data access to the index advances the pointer;
    // rewriting the index port resets it so software can restart
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fg_ptr <= 2'h0;
            bg_ptr <= 2'h0;
        end else if (i_io.wr && idx_sel) begin
            fg_ptr <= 2'h0;
            bg_ptr <= 2'h0;
        end else if ((bank_wr || bank_rd) && index_reg == SCRB_IDX_FG) begin
            fg_ptr <= scrb_ptr_step(fg_ptr);
        end else if ((bank_wr || bank_rd) && index_reg == SCRB_IDX_BG) begin
            bg_ptr <= scrb_ptr_step(bg_ptr);
        end
    end

    // Stack storage, one byte per entry
    generate
        for (genvar g = 0; g < SCRB_STACK_DEPTH; g++) begin : g_stack
            always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    fg_stack[g] <= SCRB_RST_BYTE;
                    bg_stack[g] <= SCRB_RST_BYTE;
                end else if (bank_wr) begin
                    if (index_reg == SCRB_IDX_FG && fg_ptr == 2'(g)) begin
                        fg_stack[g] <= i_io.wdata;
                    end
                    if (index_reg == SCRB_IDX_BG && bg_ptr == 2'(g)) begin
                        bg_stack[g] <= i_io.wdata;
                    end
                end
            end
        end
    endgenerate

    // Read side notes
    //   lock byte answers whether or not the bank is open
    //   unmapped bank indices raise no hit
    //   other banks leave the mux at zero
    // Apart from the lock byte, a zero with no hit is the only locked answer,
    // so a locked read cannot leak the contents of any other register of the bank.

    // Read mux; locked reads other than the lock byte return nothing and raise no hit
    always_comb begin
        next_rdata = 8'h00;
        next_rd_hit = 1'b0;
        if (i_io.rd && data_sel && index_reg == SCRB_IDX_LOCK2) begin
            next_rdata = lock_reg;
            next_rd_hit = 1'b1;
        end else if (bank_rd) begin
            next_rd_hit = 1'b1;
            case (index_reg)
                SCRB_IDX_SYS_CFG: next_rdata = sys_cfg;
                SCRB_IDX_BIOS: next_rdata = bios_flag;
                SCRB_IDX_MODE: next_rdata = mode_ctl;
                SCRB_IDX_EXT_MODE: next_rdata = ext_mode;
                SCRB_IDX_CUR_MODE: next_rdata = cur_mode;
                SCRB_IDX_ORG_X_LO: next_rdata = org_x[7:0];
                SCRB_IDX_ORG_X_HI: next_rdata = org_x[15:8];
                SCRB_IDX_ORG_Y_LO: next_rdata = org_y[7:0];
                SCRB_IDX_ORG_Y_HI: next_rdata = org_y[15:8];
                SCRB_IDX_FG: next_rdata = fg_stack[fg_ptr];
                SCRB_IDX_BG: next_rdata = bg_stack[bg_ptr];
                SCRB_IDX_PAT_LO: next_rdata = pat_addr[7:0];
                SCRB_IDX_PAT_HI: next_rdata = pat_addr[15:8];
                SCRB_IDX_OFS_X: next_rdata = ofs_x;
                SCRB_IDX_OFS_Y: next_rdata = ofs_y;
                default: next_rd_hit = 1'b0;
            endcase
        end
    end

    // Read data registered, one cycle after the strobe
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= 8'h00;
            o_rd_hit <= 1'b0;
        end else begin
            o_rdata <= next_rdata;
            o_rd_hit <= next_rd_hit;
        end
    end

    // Control bus fields
    //   enhanced access, ready control, interlace
    //   width bit 8, doubled counting
    //   cursor enable and reserved space
    //   origins, pattern address and offsets
    //   BIOS byte and both color triples
    // Reserved upper bits of the words stay inside the bank;
    // the display side cannot be fooled by a stray high byte.

    // Control outputs; reserved bits are stored but not exported
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_ctrl <= '0;
        end else begin
            o_ctrl.enh_access_en <= sys_cfg[SCRB_CFG_ENH_BIT];
            o_ctrl.rdy_wait_ctrl <= sys_cfg[SCRB_CFG_RDY_BIT];
            o_ctrl.interlace <= mode_ctl[SCRB_MODE_ILACE_BIT];
            o_ctrl.width_bit8 <= ext_mode[SCRB_EXT_WIDTH8_BIT];
            o_ctrl.hcount_double <= ext_mode[SCRB_EXT_HDBL_BIT];
            o_ctrl.cursor_en <= cur_mode[SCRB_CUR_EN_BIT];
            o_ctrl.cursor_space <= cur_mode[SCRB_CUR_SPACE_BIT];
            o_ctrl.origin_x <= org_x[10:0];
            o_ctrl.origin_y <= org_y[10:0];
            o_ctrl.pattern_addr <= pat_addr[12:0];
            o_ctrl.offset_x <= ofs_x[5:0];
            o_ctrl.offset_y <= ofs_y[5:0];
            o_ctrl.bios_flag <= bios_flag;
            o_ctrl.fg_color <= {fg_stack[2], fg_stack[1], fg_stack[0]};
            o_ctrl.bg_color <= {bg_stack[2], bg_stack[1], bg_stack[0]};
        end
    end
endmodule
`default_nettype wire

// file: rtl/scrb_pkg.sv
package scrb_pkg;
    // Port addresses of the index and data ports
    localparam logic [15:0] SCRB_PORT_INDEX_MONO = 16'h03b4;
    localparam logic [15:0] SCRB_PORT_DATA_MONO = 16'h03b5;
    localparam logic [15:0] SCRB_PORT_INDEX_COLOR = 16'h03d4;
    localparam logic [15:0] SCRB_PORT_DATA_COLOR = 16'h03d5;
    // Indices of the bank
    localparam logic [7:0] SCRB_IDX_LOCK2 = 8'h39;
    localparam logic [7:0] SCRB_IDX_SYS_CFG = 8'h40;
    localparam logic [7:0] SCRB_IDX_BIOS = 8'h41;
    localparam logic [7:0] SCRB_IDX_MODE = 8'h42;
    localparam logic [7:0] SCRB_IDX_EXT_MODE = 8'h43;
    localparam logic [7:0] SCRB_IDX_CUR_MODE = 8'h45;
    localparam logic [7:0] SCRB_IDX_ORG_X_LO = 8'h46;
    localparam logic [7:0] SCRB_IDX_ORG_X_HI = 8'h47;
    localparam logic [7:0] SCRB_IDX_ORG_Y_LO = 8'h48;
    localparam logic [7:0] SCRB_IDX_ORG_Y_HI = 8'h49;
    localparam logic [7:0] SCRB_IDX_FG = 8'h4a;
    localparam logic [7:0] SCRB_IDX_BG = 8'h4b;
    localparam logic [7:0] SCRB_IDX_PAT_LO = 8'h4c;
    localparam logic [7:0] SCRB_IDX_PAT_HI = 8'h4d;
    localparam logic [7:0] SCRB_IDX_OFS_X = 8'h4e;
    localparam logic [7:0] SCRB_IDX_OFS_Y = 8'h4f;
    // Unlock key; value is arbitrary, a parameter of the top overrides it
    localparam logic [7:0] SCRB_UNLOCK_KEY = 8'ha5;
    // Field positions
    localparam int SCRB_CFG_ENH_BIT = 0;
    localparam int SCRB_CFG_RDY_BIT = 4;
    localparam int SCRB_CFG_ONE_BIT = 5;
    localparam int SCRB_MODE_ILACE_BIT = 5;
    localparam int SCRB_EXT_WIDTH8_BIT = 2;
    localparam int SCRB_EXT_HDBL_BIT = 7;
    localparam int SCRB_CUR_EN_BIT = 0;
    localparam int SCRB_CUR_SPACE_BIT = 4;
    localparam int SCRB_STACK_DEPTH = 3;
    // Values after reset
    localparam logic [7:0] SCRB_RST_SYS_CFG = 8'h20;
    localparam logic [7:0] SCRB_RST_BYTE = 8'h00;
    localparam logic [15:0] SCRB_RST_WORD = 16'h0000;
    localparam logic [7:0] SCRB_RST_LOCK = 8'h00;

    // Host I/O cycle on the system bus
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } scrb_io_t;

    // Settings steering the display, cursor and bus logic
    typedef struct packed {
        logic enh_access_en;
        logic rdy_wait_ctrl;
        logic interlace;
        logic width_bit8;
        logic hcount_double;
        logic cursor_en;
        logic cursor_space;
        logic [10:0] origin_x;
        logic [10:0] origin_y;
        logic [12:0] pattern_addr;
        logic [5:0] offset_x;
        logic [5:0] offset_y;
        logic [7:0] bios_flag;
        logic [23:0] fg_color;
        logic [23:0] bg_color;
    } scrb_ctrl_t;
endpackage
